/* File: src/cbt_pkg.sv */
// Package: opcodes, register offsets, flag positions and reset values for the branch/bit-test unit
package cbt_pkg;
  // Branch opcodes
  localparam logic [7:0] OP_BRANCH_ALWAYS = 8'h20;
  localparam logic [7:0] OP_BRANCH_NEVER = 8'h21;
  localparam logic [7:0] OP_BRANCH_IF_HIGHER = 8'h22;
  localparam logic [7:0] OP_BRANCH_LOWER_OR_SAME = 8'h23;
  localparam logic [7:0] OP_BRANCH_NO_BORROW = 8'h24;
  localparam logic [7:0] OP_BRANCH_ON_BORROW = 8'h25;
  localparam logic [7:0] OP_BRANCH_IF_UNEQUAL = 8'h26;
  localparam logic [7:0] OP_BRANCH_IF_EQUAL = 8'h27;
  localparam logic [7:0] OP_BRANCH_NO_OVF = 8'h28;
  localparam logic [7:0] OP_BRANCH_ON_OVF = 8'h29;
  localparam logic [7:0] OP_BRANCH_IF_PLUS = 8'h2A;
  localparam logic [7:0] OP_BRANCH_IF_MINUS = 8'h2B;
  localparam logic [7:0] OP_BRANCH_SIGNED_GE = 8'h2C;
  localparam logic [7:0] OP_BRANCH_SIGNED_LESS = 8'h2D;
  localparam logic [7:0] OP_BRANCH_SIGNED_GREATER = 8'h2E;
  localparam logic [7:0] OP_BRANCH_SIGNED_LE = 8'h2F;
  // Alias names sharing the carry opcodes
  localparam logic [7:0] OP_BRANCH_HIGHER_OR_SAME = OP_BRANCH_NO_BORROW;
  localparam logic [7:0] OP_BRANCH_IF_LOWER = OP_BRANCH_ON_BORROW;
  // Bit-test opcodes
  localparam logic [7:0] OP_ATA_IMMEDIATE = 8'h85;
  localparam logic [7:0] OP_ATA_DIRECT = 8'h95;
  localparam logic [7:0] OP_ATA_INDEXED = 8'hA5;
  localparam logic [7:0] OP_ATA_EXTENDED = 8'hB5;
  localparam logic [7:0] OP_ATB_IMMEDIATE = 8'hC5;
  localparam logic [7:0] OP_ATB_DIRECT = 8'hD5;
  localparam logic [7:0] OP_ATB_INDEXED = 8'hE5;
  localparam logic [7:0] OP_ATB_EXTENDED = 8'hF5;
  // Branch step past the two-byte instruction
  localparam logic [15:0] BRANCH_STEP = 16'h0002;
  // Fetch cycles
  localparam logic [1:0] FETCH_TAKEN = 2'h3;
  localparam logic [1:0] FETCH_NOT_TAKEN = 2'h1;
  // Flag positions in flag_register (S X H I N Z V C)
  localparam int FLAG_C = 0;
  localparam int FLAG_V = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 3;
  localparam logic [7:0] FLAG_RESET = 8'hD0;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_OPCODE = 8'h04;
  localparam logic [7:0] REG_OPERAND = 8'h08;
  localparam logic [7:0] REG_PC = 8'h0C;
  localparam logic [7:0] REG_FLAGS = 8'h10;
  localparam logic [7:0] REG_ACC = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_RESULT = 8'h1C;
  // Control bits
  localparam int CTRL_GO = 0;
  // Status bits
  localparam int STAT_BUSY = 0;
  localparam int STAT_TAKEN = 1;
  localparam int STAT_ILLEGAL = 2;
  localparam int STAT_DONE = 3;
endpackage

/* File: src/cbt_cond.sv */
// Branch condition evaluator and bit-test flag computation
`timescale 1ns/1ps
module cbt_cond (
  // Decode inputs
  input wire logic [7:0] opcode,
  input wire logic [7:0] flags,
  // Bit-test operands
  input wire logic [7:0] acc_val,
  input wire logic [7:0] mem_val,
  // Results
  output logic is_branch,
  output logic taken,
  output logic is_test,
  output logic use_second,
  output logic [7:0] and_result,
  output logic [7:0] test_flags
);
  logic c;
  logic v;
  logic z;
  logic n;

  // Flag taps
  assign c = flags[cbt_pkg::FLAG_C];
  assign v = flags[cbt_pkg::FLAG_V];
  assign z = flags[cbt_pkg::FLAG_Z];
  assign n = flags[cbt_pkg::FLAG_N];
  assign is_branch = (opcode[7:4] == cbt_pkg::OP_BRANCH_ALWAYS[7:4]);

  // Condition table
  always_comb begin
    unique case (opcode)
      cbt_pkg::OP_BRANCH_ALWAYS: taken = 1'b1;
      cbt_pkg::OP_BRANCH_NEVER: taken = 1'b0;
      cbt_pkg::OP_BRANCH_IF_HIGHER: taken = ~(c | z);
      cbt_pkg::OP_BRANCH_LOWER_OR_SAME: taken = c | z;
      cbt_pkg::OP_BRANCH_HIGHER_OR_SAME: taken = ~c;
      cbt_pkg::OP_BRANCH_IF_LOWER: taken = c;
      cbt_pkg::OP_BRANCH_IF_UNEQUAL: taken = ~z;
      cbt_pkg::OP_BRANCH_IF_EQUAL: taken = z;
      cbt_pkg::OP_BRANCH_NO_OVF: taken = ~v;
      cbt_pkg::OP_BRANCH_ON_OVF: taken = v;
      cbt_pkg::OP_BRANCH_IF_PLUS: taken = ~n;
      cbt_pkg::OP_BRANCH_IF_MINUS: taken = n;
      cbt_pkg::OP_BRANCH_SIGNED_GE: taken = ~(n ^ v);
      cbt_pkg::OP_BRANCH_SIGNED_LESS: taken = n ^ v;
      cbt_pkg::OP_BRANCH_SIGNED_GREATER: taken = ~(z | (n ^ v));
      cbt_pkg::OP_BRANCH_SIGNED_LE: taken = z | (n ^ v);
      default: taken = 1'b0;
    endcase
  end

  // Bit-test decode: low nibble 5, high nibble 8..F
  assign is_test = (opcode[3:0] == cbt_pkg::OP_ATA_IMMEDIATE[3:0]) && opcode[7];
  assign use_second = opcode[6];

  // AND result; only flags change, N from MSB, Z on zero, V cleared, C kept
  assign and_result = acc_val & mem_val;
  always_comb begin
    test_flags = flags;
    test_flags[cbt_pkg::FLAG_N] = and_result[7];
    test_flags[cbt_pkg::FLAG_Z] = (and_result == 8'h00);
    test_flags[cbt_pkg::FLAG_V] = 1'b0;
  end
endmodule

/* File: src/cbt_top.sv */
// Conditional branch and bit-test execution unit with AHB-Lite register slave
// Contract
// - Taken branch loads PC with PC plus two plus signed offset.
// - Taken branch spends three fetch cycles; not taken spends one.
// - Higher-or-same branches on carry clear; alias of opcode 24.
// - Lower branches on carry set; alias of opcode 25.
// - Opcode 2F taken when Z set or N differs from V.
// - Opcode 22 taken when C and Z clear; 23 when either set.
// - 2C taken when N equals V; 2E also needs Z clear.
// - Opcode 27 taken when Z set; 26 when Z clear.
// - Opcodes 25 and 24 test only carry, set or clear.
// - Opcode 2B taken when N set; 2A when N clear.
// - Opcode 29 taken when V set; 28 when V clear.
// - Opcode 20 always taken; 21 never changes PC beyond itself.
// - Branches leave every flag register bit unchanged.
// - First-accumulator test ANDs A with operand, flags only.
// - Second-accumulator test ANDs B with operand, flags only.
// - Bit tests leave accumulator and memory unchanged.
// - Test sets N from result MSB, clears V, keeps others.
// - Test sets Z when the 8-bit result is zero.
// - First test opcodes 85, 95, B5, A5 with postbyte.
// - Second test opcodes C5, D5, F5, E5 with postbyte.
//
// Design decisions made here: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
module cbt_top #(
  parameter int PC_W = 16
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Execution status
  output logic busy_q,
  output logic [PC_W-1:0] pc_out_q
);
  typedef enum logic [1:0] {
    CBT_IDLE = 2'b00,
    CBT_EXEC = 2'b01,
    CBT_FETCH = 2'b10
  } cbt_state_e;

  cbt_state_e state_q;
  logic [7:0] opcode_q;
  logic [7:0] operand_q;
  logic [PC_W-1:0] pc_q;
  logic [7:0] flags_q;
  logic [7:0] acc_a_q;
  logic [7:0] acc_b_q;
  logic [7:0] result_q;
  logic [1:0] fetch_q;
  logic taken_q;
  logic illegal_q;
  logic done_q;
  logic [31:0] rdata_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic rd_go;
  logic go;
  logic is_branch;
  logic taken;
  logic is_test;
  logic use_second;
  logic [7:0] and_result;
  logic [7:0] test_flags;
  logic [PC_W-1:0] offset_ext;
  logic [PC_W-1:0] target;

  // Condition and bit-test evaluation
  cbt_cond u_cond (
    .opcode(opcode_q),
    .flags(flags_q),
    .acc_val(use_second ? acc_b_q : acc_a_q),
    .mem_val(operand_q),
    .is_branch(is_branch),
    .taken(taken),
    .is_test(is_test),
    .use_second(use_second),
    .and_result(and_result),
    .test_flags(test_flags)
  );

  // Sign extension then add; wraps at the PC width like the core's adder
  assign offset_ext = {{(PC_W-8){operand_q[7]}}, operand_q};
  assign target = pc_q + cbt_pkg::BRANCH_STEP[PC_W-1:0] + offset_ext;

  // Read address phase accepted for this slave; GO decoded from the pending control write in the data phase
  assign rd_go = hsel && hready && htrans[1] && !hwrite;
  assign go = wr_pend_q && (wr_addr_q == cbt_pkg::REG_CTRL) && hwdata[cbt_pkg::CTRL_GO]
    && (state_q == CBT_IDLE);

  // Always ready, always OKAY: every access finishes in one data-phase cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Write address capture for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= hsel && hready && htrans[1] && hwrite;
      wr_addr_q <= haddr;
    end
  end

  // Read data registered in the address phase, presented in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h00000000;
    end else if (rd_go) begin
      unique case (haddr)
        cbt_pkg::REG_CTRL: rdata_q <= 32'h00000000;
        cbt_pkg::REG_OPCODE: rdata_q <= {24'h000000, opcode_q};
        cbt_pkg::REG_OPERAND: rdata_q <= {24'h000000, operand_q};
        cbt_pkg::REG_PC: rdata_q <= 32'(pc_q);
        cbt_pkg::REG_FLAGS: rdata_q <= {24'h000000, flags_q};
        cbt_pkg::REG_ACC: rdata_q <= {16'h0000, acc_b_q, acc_a_q};
        cbt_pkg::REG_STATUS: rdata_q <= {28'h0000000, done_q, illegal_q, taken_q, busy_q};
        cbt_pkg::REG_RESULT: rdata_q <= {24'h000000, result_q};
        default: rdata_q <= 32'h00000000;
      endcase
    end
  end
  assign hrdata = rdata_q;

  // Sequencer: decode/execute, then count fetch cycles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= CBT_IDLE;
      fetch_q <= 2'h0;
      taken_q <= 1'b0;
      illegal_q <= 1'b0;
    end else begin
      unique case (state_q)
        CBT_IDLE: begin
          if (go) begin
            state_q <= CBT_EXEC;
          end
        end
        CBT_EXEC: begin
          illegal_q <= !(is_branch || is_test);
          taken_q <= is_branch && taken;
          state_q <= CBT_FETCH;
          if (is_branch && taken) begin
            fetch_q <= cbt_pkg::FETCH_TAKEN;
          end else begin
            fetch_q <= cbt_pkg::FETCH_NOT_TAKEN;
          end
        end
        CBT_FETCH: begin
          fetch_q <= fetch_q - 2'h1;
          if (fetch_q == 2'h1) begin
            state_q <= CBT_IDLE;
          end
        end
        default: state_q <= CBT_IDLE;
      endcase
    end
  end

  // Busy and done status
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      busy_q <= (state_q == CBT_IDLE) ? go : !(state_q == CBT_FETCH && fetch_q == 2'h1);
      if (go) begin
        done_q <= 1'b0;
      end else if (state_q == CBT_FETCH && fetch_q == 2'h1) begin
        done_q <= 1'b1;
      end
    end
  end

  // Program counter: software load or branch result
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc_q <= '0;
    end else if (state_q == CBT_EXEC && is_branch) begin
      if (taken) begin
        pc_q <= target;
      end else begin
        pc_q <= pc_q + cbt_pkg::BRANCH_STEP[PC_W-1:0];
      end
    end else if (wr_pend_q && wr_addr_q == cbt_pkg::REG_PC && state_q == CBT_IDLE) begin
      pc_q <= hwdata[PC_W-1:0];
    end
  end
  assign pc_out_q = pc_q;

  // Flag register: bit tests and software writes load it; branches leave it alone
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_q <= cbt_pkg::FLAG_RESET;
    end else if (state_q == CBT_EXEC && is_test) begin
      flags_q <= test_flags;
    end else if (wr_pend_q && wr_addr_q == cbt_pkg::REG_FLAGS && state_q == CBT_IDLE) begin
      flags_q <= hwdata[7:0];
    end
  end

  // Result register; accumulators and operand are never written by a test
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_q <= 8'h00;
    end else if (state_q == CBT_EXEC && is_test) begin
      result_q <= and_result;
    end
  end

  // Software-loaded operands, frozen while executing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      opcode_q <= 8'h00;
      operand_q <= 8'h00;
      acc_a_q <= 8'h00;
      acc_b_q <= 8'h00;
    end else if (wr_pend_q && state_q == CBT_IDLE) begin
      if (wr_addr_q == cbt_pkg::REG_OPCODE) begin
        opcode_q <= hwdata[7:0];
      end
      if (wr_addr_q == cbt_pkg::REG_OPERAND) begin
        operand_q <= hwdata[7:0];
      end
      if (wr_addr_q == cbt_pkg::REG_ACC) begin
        acc_a_q <= hwdata[7:0];
        acc_b_q <= hwdata[15:8];
      end
    end
  end

  // Branch never touches flags
  property p_branch_keeps_flags;
    @(posedge hclk) disable iff (!hresetn)
      (state_q == CBT_EXEC && is_branch) |=> $stable(flags_q);
  endproperty
  a_branch_keeps_flags: assert property (p_branch_keeps_flags)
    else $error("branch changed flags");

  // Taken branch target
  property p_taken_target;
    @(posedge hclk) disable iff (!hresetn)
      (state_q == CBT_EXEC && is_branch && taken) |=>
        pc_q == $past(pc_q) + 16'h0002 + {{8{$past(operand_q[7])}}, $past(operand_q)};
  endproperty
  a_taken_target: assert property (p_taken_target)
    else $error("taken branch target wrong");

  // Not taken step
  property p_not_taken_step;
    @(posedge hclk) disable iff (!hresetn)
      (state_q == CBT_EXEC && is_branch && !taken) |=> pc_q == $past(pc_q) + 16'h0002;
  endproperty
  a_not_taken_step: assert property (p_not_taken_step)
    else $error("untaken branch PC wrong");

  // Taken branch spends three fetch cycles
  property p_taken_fetch;
    @(posedge hclk) disable iff (!hresetn)
      (state_q == CBT_EXEC && is_branch && taken) |=>
        (state_q == CBT_FETCH) [*3] ##1 (state_q == CBT_IDLE);
  endproperty
  a_taken_fetch: assert property (p_taken_fetch)
    else $error("taken branch fetch count wrong");

  // Untaken branch spends one fetch cycle
  property p_untaken_fetch;
    @(posedge hclk) disable iff (!hresetn)
      (state_q == CBT_EXEC && is_branch && !taken) |=>
        (state_q == CBT_FETCH) ##1 (state_q == CBT_IDLE);
  endproperty
  a_untaken_fetch: assert property (p_untaken_fetch)
    else $error("untaken branch fetch count wrong");

  // Bit test flags
  property p_test_flags;
    @(posedge hclk) disable iff (!hresetn)
      (state_q == CBT_EXEC && is_test) |=>
        flags_q[cbt_pkg::FLAG_V] == 1'b0
        && flags_q[cbt_pkg::FLAG_Z] == (result_q == 8'h00)
        && flags_q[cbt_pkg::FLAG_N] == result_q[7]
        && flags_q[cbt_pkg::FLAG_C] == $past(flags_q[cbt_pkg::FLAG_C]);
  endproperty
  a_test_flags: assert property (p_test_flags)
    else $error("bit test flags wrong");

  // Bit test keeps accumulators and operand
  property p_test_keeps_acc;
    @(posedge hclk) disable iff (!hresetn)
      (state_q == CBT_EXEC && is_test) |=> $stable(acc_a_q) && $stable(acc_b_q)
        && $stable(operand_q);
  endproperty
  a_test_keeps_acc: assert property (p_test_keeps_acc)
    else $error("bit test altered operand");

  // Bit test result is the AND of the chosen accumulator
  property p_test_result;
    @(posedge hclk) disable iff (!hresetn)
      (state_q == CBT_EXEC && is_test) |=>
        result_q == ((opcode_q[6] ? acc_b_q : acc_a_q) & operand_q);
  endproperty
  a_test_result: assert property (p_test_result)
    else $error("bit test result wrong");

  // Busy stays high through all three refill cycles of a taken branch, then drops
  property p_busy_taken;
    @(posedge hclk) disable iff (!hresetn)
      (state_q == CBT_EXEC && is_branch && taken) |=>
        busy_q [*3] ##1 !busy_q;
  endproperty
  a_busy_taken: assert property (p_busy_taken)
    else $error("busy length of taken branch wrong");

  // A bit test only touches flags and the result register; the program counter is left for the core
  property p_test_keeps_pc;
    @(posedge hclk) disable iff (!hresetn)
      (state_q == CBT_EXEC && is_test) |=> $stable(pc_q);
  endproperty
  a_test_keeps_pc: assert property (p_test_keeps_pc)
    else $error("bit test moved program counter");

  // Unconditional branch reports taken whatever the flags hold
  property p_always_taken;
    @(posedge hclk) disable iff (!hresetn)
      (state_q == CBT_EXEC && opcode_q == cbt_pkg::OP_BRANCH_ALWAYS) |=> taken_q;
  endproperty
  a_always_taken: assert property (p_always_taken)
    else $error("unconditional branch not taken");

  // Carry branch decides on carry alone, whatever the other flags say
  property p_borrow_branch;
    @(posedge hclk) disable iff (!hresetn)
      (state_q == CBT_EXEC && opcode_q == cbt_pkg::OP_BRANCH_ON_BORROW) |=>
        taken_q == $past(flags_q[cbt_pkg::FLAG_C]);
  endproperty
  a_borrow_branch: assert property (p_borrow_branch)
    else $error("carry branch decision wrong");
endmodule

/* File: dv/cbt_host.sv */
// Bus master model: single-word AHB-Lite transfers into the unit
`timescale 1ns/1ps
module cbt_host (
  // Clock and slave return
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Master request
  output logic hsel,
  output logic [7:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  // Idle bus from time zero
  initial begin
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // One word transfer; waits for as long as the slave stalls
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    // Stale write data is inverted so it never passes for a fresh value
    hwdata <= ~wd;
  endtask
endmodule

/* File: dv/cbt_top_tb.sv */
// Self-checking bench for the branch and bit-test unit
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin errors++; \
  $display("Error %s expected %h seen %h", nm, exp, got); end end
module cbt_top_tb;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic busy_q;
  logic [15:0] pc_out_q;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;

  cbt_host host_inst (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  cbt_top #(.PC_W(16)) cbt_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .busy_q(busy_q), .pc_out_q(pc_out_q));

  // Clock at 4 ns period
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  // Hang guard, well above the expected run length
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      errors++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("Checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    host_inst.xfer(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    host_inst.xfer(1'b0, a, 32'h0, d);
  endtask

  // Load operands, start, and count busy cycles over a fixed window
  task automatic run_op(input logic [7:0] op, opnd, fl, input logic [15:0] pc, acc,
                        output int busy);
    wr(cbt_pkg::REG_OPCODE, {24'h0, op});
    wr(cbt_pkg::REG_OPERAND, {24'h0, opnd});
    wr(cbt_pkg::REG_PC, {16'h0, pc});
    wr(cbt_pkg::REG_FLAGS, {24'h0, fl});
    wr(cbt_pkg::REG_ACC, {16'h0, acc});
    wr(cbt_pkg::REG_CTRL, 32'h1);
    busy = 0;
    // First look just after the GO edge, so the execute cycle is counted too
    repeat (20) begin
      #1;
      if (busy_q === 1'b1)
        busy++;
      @(posedge hclk);
    end
  endtask

  // Reference branch decision from the NZVC flags
  function automatic logic exp_taken(input logic [7:0] op, input logic [3:0] f);
    logic n, z, v, c;
    {n, z, v, c} = f;
    case (op[3:0])
      4'h0: return 1'b1;
      4'h1: return 1'b0;
      4'h2: return !(c | z);
      4'h3: return c | z;
      4'h4: return !c;
      4'h5: return c;
      4'h6: return !z;
      4'h7: return z;
      4'h8: return !v;
      4'h9: return v;
      4'hA: return !n;
      4'hB: return n;
      4'hC: return !(n ^ v);
      4'hD: return n ^ v;
      4'hE: return !(z | (n ^ v));
      default: return z | (n ^ v);
    endcase
  endfunction

  task automatic test_reset();
    logic [31:0] d;
    `CHK("busy", 1'b0, busy_q)
    `CHK("pc_out", 16'h0, pc_out_q)
    `CHK("hresp", 1'b0, hresp)
    `CHK("hreadyout", 1'b1, hreadyout)
    rd(cbt_pkg::REG_FLAGS, d);
    `CHK("flags rst", {24'h0, cbt_pkg::FLAG_RESET}, d)
    rd(8'h40, d);
    `CHK("unmapped", 32'h0, d)
    $display("Reset test done");
  endtask

  // Every branch opcode against every NZVC pattern, both offset signs
  task automatic test_branches();
    logic [31:0] d;
    logic [7:0] op, off, fl;
    logic [15:0] pc, epc;
    logic t;
    int busy;
    for (int o = 0; o < 16; o++) begin
      for (int f = 0; f < 16; f++) begin
        op = 8'h20 + 8'(o);
        off = f[0] ? 8'h80 : 8'h7F;
        pc = f[1] ? 16'hFFF0 : 16'h1234;
        fl = {4'h5, 4'(f)};
        t = exp_taken(op, 4'(f));
        epc = pc + cbt_pkg::BRANCH_STEP + (t ? {{8{off[7]}}, off} : 16'h0);
        run_op(op, off, fl, pc, 16'hA55A, busy);
        rd(cbt_pkg::REG_PC, d);
        `CHK("pc", {16'h0, epc}, d)
        `CHK("pc_out", epc, pc_out_q)
        rd(cbt_pkg::REG_FLAGS, d);
        `CHK("flags", {24'h0, fl}, d)
        rd(cbt_pkg::REG_STATUS, d);
        `CHK("status", {28'h0, 1'b1, 1'b0, t, 1'b0}, d)
        `CHK("taken", t, d[1])
        `CHK("busy cycles", t ? 4 : 2, busy)
      end
    end
    $display("Branch test done");
  endtask

  // All eight bit-test encodings, zero and negative results included
  task automatic test_bits();
    logic [7:0] ops [8] = '{8'h85, 8'h95, 8'hA5, 8'hB5, 8'hC5, 8'hD5, 8'hE5, 8'hF5};
    logic [7:0] av [3] = '{8'hF0, 8'h0F, 8'h3C};
    logic [7:0] bv [3] = '{8'h0F, 8'hF3, 8'h00};
    logic [7:0] mv [3] = '{8'h8F, 8'hF0, 8'h7E};
    logic [31:0] d;
    logic [7:0] res, fl, efl;
    int busy;
    for (int k = 0; k < 8; k++) begin
      for (int i = 0; i < 3; i++) begin
        fl = i[0] ? 8'hA3 : 8'h52;
        res = (ops[k][6] ? bv[i] : av[i]) & mv[i];
        efl = {fl[7:4], res[7], res == 8'h00, 1'b0, fl[0]};
        run_op(ops[k], mv[i], fl, 16'h4000, {bv[i], av[i]}, busy);
        rd(cbt_pkg::REG_RESULT, d);
        `CHK("and result", {24'h0, res}, d)
        rd(cbt_pkg::REG_FLAGS, d);
        `CHK("flags nv", efl[3:0], d[3:0])
        `CHK("flags z", efl, d[7:0])
        rd(cbt_pkg::REG_ACC, d);
        `CHK("acc", {16'h0, bv[i], av[i]}, d)
        rd(cbt_pkg::REG_STATUS, d);
        `CHK("status", 32'h8, d)
      end
    end
    $display("Bit test done");
  endtask

  // Opcode outside both groups changes nothing
  task automatic test_illegal();
    logic [31:0] d;
    int busy;
    run_op(8'h00, 8'h10, 8'hD5, 16'h2000, 16'h0000, busy);
    rd(cbt_pkg::REG_STATUS, d);
    `CHK("illegal", 32'hC, d)
    rd(cbt_pkg::REG_FLAGS, d);
    `CHK("flags kept", 32'hD5, d)
    $display("Illegal test done");
  endtask

  // Reset for two cycles, then the scenarios
  initial begin
    hresetn = 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    test_reset();
    test_branches();
    test_bits();
    test_illegal();
    complete_run();
  end
endmodule
